// ### inc/vft_regs.vh
// Register map, field layout and timing constants of the video frame timing block.
//
// How it works
// - 32-bit ancillary line stride in bytes.
// - Stride used only in raster storage mode.
// - Blanking span from bits 26 to 16.
// - Active span from bits 10 to 0.
// - Spans exclude four-byte timing code bytes.
// - Vertical line counter starts at one.
// - Marker writes take effect at once.
// - Config0 holds marker one and three.
// - Config1 holds marker five and seven.
// - Config2 holds marker nine and eleven.
// - Markers seven, nine, eleven interlace only.
`ifndef VFT_REGS_VH
`define VFT_REGS_VH

`define VFT_ADDR_CTRL     12'h000
`define VFT_ADDR_STRIDE   12'h004
`define VFT_ADDR_HSPAN    12'h008
`define VFT_ADDR_VMARK0   12'h00c
`define VFT_ADDR_VMARK1   12'h010
`define VFT_ADDR_VMARK2   12'h014
`define VFT_ADDR_STATUS   12'h018
`define VFT_ADDR_STRADDR  12'h01c

`define VFT_HI_MSB        26
`define VFT_HI_LSB        16
`define VFT_LO_MSB        10
`define VFT_LO_LSB        0
`define VFT_FIELD_MASK    32'h07ff07ff

`define VFT_CTRL_ENABLE   0
`define VFT_CTRL_ILACE    1
`define VFT_CTRL_SUBPIC   2
`define VFT_CTRL_MASK     32'h00000007

`define VFT_CODE_BYTES    11'h004
`define VFT_LINE_FIRST    11'h001
`define VFT_ZERO32        32'h00000000
`define VFT_ZERO11        11'h000
`define VFT_ONE11         11'h001

`define VFT_ST_HBLANK     2'h0
`define VFT_ST_SAV        2'h1
`define VFT_ST_ACTIVE     2'h2
`define VFT_ST_EAV        2'h3

`endif

// ### rtl/vft_hcount.v
// Horizontal byte sequencer: timing code, blanking and active spans of one line.
`timescale 1ns/1ps
module vft_hcount (
  // Clock and reset.
  input  wire        pclk,
  input  wire        presetn,
  // Control.
  input  wire        run,
  input  wire [10:0] blank_span_bytes,
  input  wire [10:0] active_span_bytes,
  // Status.
  output reg  [1:0]  hstate_q,
  output reg         line_end_q,
  output reg         active_q
);
`include "vft_regs.vh"

  reg [10:0] cnt_q;
  reg [10:0] cnt_d;
  reg [1:0]  hstate_d;
  reg        line_end_d;

  // The code bytes are counted apart from the spans so a zero span still emits its code.
  always @* begin
    cnt_d      = cnt_q + `VFT_ONE11;
    hstate_d   = hstate_q;
    line_end_d = 1'b0;
    case (hstate_q)
      `VFT_ST_HBLANK: begin
        if (cnt_q >= blank_span_bytes) begin
          hstate_d = `VFT_ST_SAV;
          cnt_d    = `VFT_ONE11;
        end
      end
      `VFT_ST_SAV: begin
        if (cnt_q >= `VFT_CODE_BYTES) begin
          hstate_d = `VFT_ST_ACTIVE;
          cnt_d    = `VFT_ONE11;
        end
      end
      `VFT_ST_ACTIVE: begin
        if (cnt_q >= active_span_bytes) begin
          hstate_d = `VFT_ST_EAV;
          cnt_d    = `VFT_ONE11;
        end
      end
      `VFT_ST_EAV: begin
        if (cnt_q >= `VFT_CODE_BYTES) begin
          hstate_d   = `VFT_ST_HBLANK;
          cnt_d      = `VFT_ONE11;
          line_end_d = 1'b1;
        end
      end
      default: begin
        hstate_d = `VFT_ST_HBLANK;
        cnt_d    = `VFT_ONE11;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q      <= `VFT_ONE11;
      hstate_q   <= `VFT_ST_HBLANK;
      line_end_q <= 1'b0;
      active_q   <= 1'b0;
    end else if (!run) begin
      cnt_q      <= `VFT_ONE11;
      hstate_q   <= `VFT_ST_HBLANK;
      line_end_q <= 1'b0;
      active_q   <= 1'b0;
    end else begin
      cnt_q      <= cnt_d;
      hstate_q   <= hstate_d;
      line_end_q <= line_end_d;
      active_q   <= (hstate_d == `VFT_ST_ACTIVE);
    end
  end

endmodule // vft_hcount

// ### rtl/vft_top.v
// APB register bank and frame timing top of one video output channel.
`timescale 1ns/1ps
module vft_top (
  // Clock and reset.
  input  wire        pclk,
  input  wire        presetn,
  // APB slave.
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Timing outputs.
  output reg  [1:0]  hstate,
  output reg         line_end,
  output reg         video_active,
  output reg         field_bottom,
  output reg         frame_start,
  output reg  [10:0] line_number,
  // Ancillary address.
  output reg  [31:0] hanc_line_addr
);
`include "vft_regs.vh"

  ////////////////////////////////////////////////////////////////////////////
  // Register bank.

  reg  [31:0] channel_control_q;
  reg  [31:0] hanc_line_stride_q;
  reg  [31:0] horizontal_span_config_q;
  reg  [31:0] vertical_marker_config_0_q;
  reg  [31:0] vertical_marker_config_1_q;
  reg  [31:0] vertical_marker_config_2_q;
  reg  [31:0] hanc_base_q;
  reg  [31:0] addr_q;
  reg  [31:0] rdata_d;
  reg         hit_d;

  wire        setup   = psel && !penable;
  wire        wr_take = psel && penable && pready && pwrite && !pslverr;

  function known_addr;
    input [11:0] a;
    begin
      known_addr = (a == `VFT_ADDR_CTRL)   || (a == `VFT_ADDR_STRIDE) ||
                   (a == `VFT_ADDR_HSPAN)  || (a == `VFT_ADDR_VMARK0) ||
                   (a == `VFT_ADDR_VMARK1) || (a == `VFT_ADDR_VMARK2) ||
                   (a == `VFT_ADDR_STATUS) || (a == `VFT_ADDR_STRADDR);
    end
  endfunction

  function [10:0] hi_field;
    input [31:0] r;
    begin
      hi_field = r[`VFT_HI_MSB:`VFT_HI_LSB];
    end
  endfunction

  function [10:0] lo_field;
    input [31:0] r;
    begin
      lo_field = r[`VFT_LO_MSB:`VFT_LO_LSB];
    end
  endfunction

  wire run    = channel_control_q[`VFT_CTRL_ENABLE];
  wire ilace  = channel_control_q[`VFT_CTRL_ILACE];
  wire subpic = channel_control_q[`VFT_CTRL_SUBPIC];

  // Status word built from the live timing state.
  wire [31:0] status_word;

  always @* begin
    hit_d   = known_addr(paddr);
    rdata_d = `VFT_ZERO32;
    case (paddr)
      `VFT_ADDR_CTRL:    rdata_d = channel_control_q;
      `VFT_ADDR_STRIDE:  rdata_d = hanc_line_stride_q;
      `VFT_ADDR_HSPAN:   rdata_d = horizontal_span_config_q;
      `VFT_ADDR_VMARK0:  rdata_d = vertical_marker_config_0_q;
      `VFT_ADDR_VMARK1:  rdata_d = vertical_marker_config_1_q;
      `VFT_ADDR_VMARK2:  rdata_d = vertical_marker_config_2_q;
      `VFT_ADDR_STATUS:  rdata_d = status_word;
      `VFT_ADDR_STRADDR: rdata_d = hanc_base_q;
      default:           rdata_d = `VFT_ZERO32;
    endcase
  end

  // No wait state: the answer is decoded in setup and presented in the first access cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `VFT_ZERO32;
    end else if (setup) begin
      pready  <= 1'b1;
      pslverr <= !hit_d;
      prdata  <= pwrite ? `VFT_ZERO32 : rdata_d;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `VFT_ZERO32;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_control_q          <= `VFT_ZERO32;
      hanc_line_stride_q         <= `VFT_ZERO32;
      horizontal_span_config_q   <= `VFT_ZERO32;
      vertical_marker_config_0_q <= `VFT_ZERO32;
      vertical_marker_config_1_q <= `VFT_ZERO32;
      vertical_marker_config_2_q <= `VFT_ZERO32;
      hanc_base_q                <= `VFT_ZERO32;
    end else if (wr_take) begin
      case (paddr)
        `VFT_ADDR_CTRL:    channel_control_q <= pwdata & `VFT_CTRL_MASK;
        // Low stride bits are kept as written; software keeps 8-byte alignment.
        `VFT_ADDR_STRIDE:  hanc_line_stride_q <= pwdata;
        `VFT_ADDR_HSPAN:   horizontal_span_config_q <= pwdata & `VFT_FIELD_MASK;
        `VFT_ADDR_VMARK0:  vertical_marker_config_0_q <= pwdata & `VFT_FIELD_MASK;
        `VFT_ADDR_VMARK1:  vertical_marker_config_1_q <= pwdata & `VFT_FIELD_MASK;
        `VFT_ADDR_VMARK2:  vertical_marker_config_2_q <= pwdata & `VFT_FIELD_MASK;
        `VFT_ADDR_STRADDR: hanc_base_q <= pwdata;
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timing engines.

  wire [1:0]  h_state;
  wire        h_line_end;
  wire        h_active;
  wire [10:0] v_line;
  wire        v_active;
  wire        v_field;
  wire        v_frame;

  vft_hcount u_hcount (
    .pclk              (pclk),
    .presetn           (presetn),
    .run               (run),
    .blank_span_bytes  (hi_field(horizontal_span_config_q)),
    .active_span_bytes (lo_field(horizontal_span_config_q)),
    .hstate_q          (h_state),
    .line_end_q        (h_line_end),
    .active_q          (h_active)
  );

  vft_vcount u_vcount (
    .pclk              (pclk),
    .presetn           (presetn),
    .run               (run),
    .line_end          (h_line_end),
    .interlace_select  (ilace),
    .vline_mark_one    (hi_field(vertical_marker_config_0_q)),
    .vline_mark_three  (lo_field(vertical_marker_config_0_q)),
    .vline_mark_five   (hi_field(vertical_marker_config_1_q)),
    .vline_mark_seven  (lo_field(vertical_marker_config_1_q)),
    .vline_mark_nine   (hi_field(vertical_marker_config_2_q)),
    .vline_mark_eleven (lo_field(vertical_marker_config_2_q)),
    .line_q            (v_line),
    .vactive_q         (v_active),
    .field_q           (v_field),
    .frame_start_q     (v_frame)
  );

  assign status_word = {16'h0000, v_field, v_active, h_state, 1'b0, v_line};

  ////////////////////////////////////////////////////////////////////////////
  // Ancillary line address and registered outputs.

  // In sub-picture storage the stride is not applied and the base is held.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= `VFT_ZERO32;
    end else if (!run || v_frame) begin
      addr_q <= hanc_base_q;
    end else if (h_line_end && !subpic) begin
      addr_q <= addr_q + hanc_line_stride_q;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hstate         <= `VFT_ST_HBLANK;
      line_end       <= 1'b0;
      video_active   <= 1'b0;
      field_bottom   <= 1'b0;
      frame_start    <= 1'b0;
      line_number    <= `VFT_LINE_FIRST;
      hanc_line_addr <= `VFT_ZERO32;
    end else begin
      hstate         <= h_state;
      line_end       <= h_line_end;
      video_active   <= h_active && v_active;
      field_bottom   <= v_field;
      frame_start    <= v_frame;
      line_number    <= v_line;
      hanc_line_addr <= subpic ? hanc_base_q : addr_q;
    end
  end

endmodule // vft_top

// ### rtl/vft_vcount.v
// Vertical line counter and region decode against the line markers.
`timescale 1ns/1ps
module vft_vcount (
  // Clock and reset.
  input  wire        pclk,
  input  wire        presetn,
  // Control.
  input  wire        run,
  input  wire        line_end,
  input  wire        interlace_select,
  input  wire [10:0] vline_mark_one,
  input  wire [10:0] vline_mark_three,
  input  wire [10:0] vline_mark_five,
  input  wire [10:0] vline_mark_seven,
  input  wire [10:0] vline_mark_nine,
  input  wire [10:0] vline_mark_eleven,
  // Status.
  output reg  [10:0] line_q,
  output reg         vactive_q,
  output reg         field_q,
  output reg         frame_start_q
);
`include "vft_regs.vh"

  reg [10:0] line_d;
  reg        vactive_d;
  reg        field_d;
  reg        wrap;

  // Markers are read live from the register bank; no frame-boundary shadow exists.
  always @* begin
    line_d    = line_q;
    vactive_d = vactive_q;
    field_d   = field_q;
    wrap      = 1'b0;
    if (line_end) begin
      line_d = line_q + `VFT_ONE11;
      if (interlace_select) begin
        if (line_q == vline_mark_three) vactive_d = 1'b1;
        if (line_q == vline_mark_five)  vactive_d = 1'b0;
        if (line_q == vline_mark_seven) field_d   = 1'b1;
        if (line_q == vline_mark_nine)  vactive_d = 1'b1;
        if (line_q == vline_mark_eleven) begin
          vactive_d = 1'b0;
          wrap      = 1'b1;
        end
      end else begin
        if (line_q == vline_mark_three) vactive_d = 1'b1;
        if (line_q == vline_mark_five) begin
          vactive_d = 1'b0;
          wrap      = 1'b1;
        end
      end
      if (line_q == vline_mark_one) field_d = 1'b0;
      if (wrap) begin
        line_d  = `VFT_LINE_FIRST;
        field_d = 1'b0;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_q        <= `VFT_LINE_FIRST;
      vactive_q     <= 1'b0;
      field_q       <= 1'b0;
      frame_start_q <= 1'b0;
    end else if (!run) begin
      line_q        <= `VFT_LINE_FIRST;
      vactive_q     <= 1'b0;
      field_q       <= 1'b0;
      frame_start_q <= 1'b0;
    end else begin
      line_q        <= line_d;
      vactive_q     <= vactive_d;
      field_q       <= field_d;
      frame_start_q <= wrap;
    end
  end

endmodule // vft_vcount

// ### verification/tb_top.sv
// Self-checking bench of the frame timing block.
`timescale 1ns/1ps
`include "vft_regs.vh"
module tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, hanc_line_addr, rd, a0;
  logic [15:0] line_len, act_len, frame_len, vid_len;
  logic [10:0] line_number;
  logic [1:0]  hstate;
  logic        pready, pslverr, line_end, video_active, field_bottom, frame_start;
  logic        field_seen, err;
  logic [76:0] rows [7];
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cyc = 0;
  ////////////////////////////////////////////////////////////////////////////////
  always #25 pclk = ~pclk;
  vft_top dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hstate(hstate), .line_end(line_end), .video_active(video_active),
    .field_bottom(field_bottom), .frame_start(frame_start),
    .line_number(line_number), .hanc_line_addr(hanc_line_addr)
  );
  vft_enc_model u_enc (
    .pclk(pclk), .presetn(presetn), .hstate(hstate), .line_end(line_end),
    .frame_start(frame_start), .field_bottom(field_bottom), .video_active(video_active),
    .line_len(line_len), .act_len(act_len), .frame_len(frame_len), .vid_len(vid_len),
    .field_seen(field_seen)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Holds the request until pready is seen, then idles one cycle before the next.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k == 16) n_mismatch++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wev(input logic fs);
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while ((fs ? frame_start : line_end) !== 1'b1 && k < 4000);
    if (k == 4000) n_mismatch++;
    @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rows = '{{12'h004, 32'hfffffff8, 32'hfffffff8, 1'b0},
             {12'h008, 32'hfffefffe, 32'h07fe07fe, 1'b0},
             {12'h00c, 32'hffffffff, 32'h07ff07ff, 1'b0},
             {12'h010, 32'hffffffff, 32'h07ff07ff, 1'b0},
             {12'h014, 32'hffffffff, 32'h07ff07ff, 1'b0},
             {12'h01c, 32'h12345678, 32'h12345678, 1'b0},
             {12'h020, 32'h5a5a5a5a, 32'h00000000, 1'b1}};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, rows[i][76:65], 32'h00000000);
      chk(rd, 32'h00000000);
      apb(1'b1, rows[i][76:65], rows[i][64:33]);
      apb(1'b0, rows[i][76:65], 32'h00000000);
      chk(rd, rows[i][32:1]);
      chk({31'h0, err}, {31'h0, rows[i][0]});
    end
    apb(1'b1, `VFT_ADDR_HSPAN, 32'h00060008);
    apb(1'b1, `VFT_ADDR_VMARK0, 32'h00010002);
    apb(1'b1, `VFT_ADDR_VMARK1, 32'h00040004);
    apb(1'b1, `VFT_ADDR_VMARK2, 32'h00060008);
    apb(1'b1, `VFT_ADDR_STRADDR, 32'h00001000);
    apb(1'b1, `VFT_ADDR_STRIDE, 32'h00000040);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, `VFT_ADDR_CTRL, m ? 32'h00000003 : 32'h00000001);
      wev(1'b1);
      wev(1'b1);
      chk({16'h0000, line_len}, 32'h00000016);
      chk({16'h0000, act_len}, 32'h00000008);
      chk({16'h0000, frame_len}, m ? 32'h000000b0 : 32'h00000058);
      chk({31'h0, field_seen}, m ? 32'h00000001 : 32'h00000000);
      chk({16'h0000, vid_len}, m ? 32'h00000020 : 32'h00000010);
    end
    apb(1'b1, `VFT_ADDR_CTRL, 32'h00000001);
    wev(1'b1);
    apb(1'b1, `VFT_ADDR_VMARK1, 32'h00060004);
    wev(1'b1);
    chk({16'h0000, frame_len}, 32'h00000084);
    chk({16'h0000, vid_len}, 32'h00000020);
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, `VFT_ADDR_CTRL, s ? 32'h00000005 : 32'h00000001);
      wev(1'b1);
      wev(1'b0);
      a0 = hanc_line_addr;
      wev(1'b0);
      chk(hanc_line_addr - a0, s ? 32'h00000000 : 32'h00000040);
    end
    // A reset in mid-run must bring the counters and the bank back to their start.
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({21'h0, line_number}, 32'h00000001);
    chk({30'h0, frame_start, video_active}, 32'h00000000);
    chk(hanc_line_addr, 32'h00000000);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `VFT_ADDR_VMARK0, 32'h00000000);
    chk(rd, 32'h00000000);
    apb(1'b0, `VFT_ADDR_STATUS, 32'h00000000);
    chk(rd, 32'h00000001);
    conclude;
  end
endmodule // tb_top

// ### verification/vft_asserts.sv
// Port-level checks of the frame timing top.
`timescale 1ns/1ps
module vft_asserts (
  // Clock and reset.
  input wire logic        pclk,
  input wire logic        presetn,
  // APB slave.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Timing outputs.
  input wire logic [1:0]  hstate,
  input wire logic        line_end,
  input wire logic        frame_start,
  input wire logic [10:0] line_number
);
  logic [10:0] span_q;
  logic [11:0] act_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  // The span is mirrored from bus writes, so the count is judged at the ports alone.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      span_q <= 11'h000;
      act_q  <= 12'h000;
    end else begin
      if (psel && penable && pready && pwrite && paddr == 12'h008) begin
        span_q <= pwdata[10:0];
      end
      act_q <= (hstate == 2'h2) ? act_q + 12'h001 : 12'h000;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  AST_APB_ANSWER:
    assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  AST_UNMAPPED:
    assert property (pready && paddr > 12'h01c |-> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");
  AST_RSVD_ZERO:
    assert property (pready && !pwrite && paddr >= 12'h008 && paddr <= 12'h014
      |-> (prdata & 32'hf800f800) == 32'h00000000)
    else $error("reserved bits not zero");
  AST_LINE_ONE:
    assert property (line_number != 11'h000)
    else $error("line count reached zero");
  AST_FRAME_ONE:
    assert property (frame_start |-> ##[0:1] line_number == 11'h001)
    else $error("frame does not restart at one");
  AST_SAV_LEN:
    assert property ($rose(hstate == 2'h1) |-> (hstate == 2'h1) [*4] ##1 hstate == 2'h2)
    else $error("start code not four bytes");
  AST_EAV_LEN:
    assert property ($rose(hstate == 2'h3) |-> (hstate == 2'h3) [*4] ##[0:1] line_end)
    else $error("end code not four bytes");
  AST_ACT_SPAN:
    assert property ($fell(hstate == 2'h2)
      |-> act_q == ((span_q == 11'h000) ? 12'h001 : {1'b0, span_q}))
    else $error("active span length wrong");
endmodule // vft_asserts

bind vft_top vft_asserts u_vft_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .hstate(hstate), .line_end(line_end), .frame_start(frame_start),
  .line_number(line_number)
);

// ### verification/vft_enc_model.sv
// Behavioural encoder sink that measures line and frame geometry.
`timescale 1ns/1ps
module vft_enc_model (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Byte stream timing.
  input  wire logic [1:0]  hstate,
  input  wire logic        line_end,
  input  wire logic        frame_start,
  input  wire logic        field_bottom,
  input  wire logic        video_active,
  // Measured geometry.
  output logic      [15:0] line_len,
  output logic      [15:0] act_len,
  output logic      [15:0] frame_len,
  output logic      [15:0] vid_len,
  output logic             field_seen
);
  logic [15:0] lc_q, ac_q, fc_q, vc_q;
  logic        fb_q;
  ////////////////////////////////////////////////////////////////////////////////
  // A sink cannot push back, so the channel never stalls on it.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {lc_q, ac_q, fc_q, vc_q, fb_q} <= 65'h0;
      {line_len, act_len, frame_len, vid_len, field_seen} <= 65'h0;
    end else begin
      lc_q <= line_end ? 16'h0001 : lc_q + 16'h0001;
      ac_q <= line_end ? 16'h0000 : ac_q + {15'h0000, hstate == 2'h2};
      fc_q <= frame_start ? 16'h0001 : fc_q + 16'h0001;
      vc_q <= frame_start ? 16'h0000 : vc_q + {15'h0000, video_active};
      fb_q <= frame_start ? 1'b0 : fb_q | field_bottom;
      if (line_end) begin
        line_len <= lc_q;
        act_len  <= ac_q;
      end
      if (frame_start) begin
        frame_len  <= fc_q;
        vid_len    <= vc_q;
        field_seen <= fb_q | field_bottom;
      end
    end
  end
endmodule // vft_enc_model
